// *** hw/sram_ctrl_pkg.sv ***
package sram_ctrl_pkg;

  // memory geometry
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned WORD_COUNT = 1024;

  // clock period in picoseconds (40 MHz)
  localparam int unsigned CLK_PS = 25000;

  // device timing figures in ns, fast grade by default
  localparam int unsigned ADDR_TO_OUTPUT_DELAY_NS     = 20;
  localparam int unsigned SELECT_TO_OUTPUT_DELAY_NS   = 15;
  localparam int unsigned DESELECT_TO_FLOAT_DELAY_NS  = 20;
  localparam int unsigned WRITE_TO_FLOAT_DELAY_NS     = 15;
  localparam int unsigned WRITE_PULSE_WIDTH_NS        = 15;
  localparam int unsigned DATA_SETUP_BEFORE_WRITE_NS  = 0;
  localparam int unsigned DATA_HOLD_AFTER_WRITE_NS    = 0;
  localparam int unsigned ADDR_SETUP_BEFORE_WRITE_NS  = 5;
  localparam int unsigned ADDR_HOLD_AFTER_WRITE_NS    = 0;
  localparam int unsigned SELECT_SETUP_BEFORE_WRITE_NS = 5;
  localparam int unsigned SELECT_HOLD_AFTER_WRITE_NS  = 0;

  // least times round up, at least one cycle
  function automatic int unsigned min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // stages of the memory output sampler
  localparam int unsigned SYNC_STAGES = 3;

  // read wait covers the access time, then the bit crossing all sampler stages
  localparam int unsigned READ_WAIT_CYCLES =
    min_cycles((ADDR_TO_OUTPUT_DELAY_NS > SELECT_TO_OUTPUT_DELAY_NS) ?
               ADDR_TO_OUTPUT_DELAY_NS : SELECT_TO_OUTPUT_DELAY_NS) + SYNC_STAGES;
  localparam int unsigned SETUP_CYCLES =
    min_cycles((ADDR_SETUP_BEFORE_WRITE_NS > SELECT_SETUP_BEFORE_WRITE_NS) ?
               ADDR_SETUP_BEFORE_WRITE_NS : SELECT_SETUP_BEFORE_WRITE_NS);
  localparam int unsigned PULSE_CYCLES = min_cycles(WRITE_PULSE_WIDTH_NS);
  localparam int unsigned HOLD_CYCLES =
    min_cycles((ADDR_HOLD_AFTER_WRITE_NS > DATA_HOLD_AFTER_WRITE_NS) ?
               ADDR_HOLD_AFTER_WRITE_NS : DATA_HOLD_AFTER_WRITE_NS);
  localparam int unsigned FLOAT_CYCLES = min_cycles(DESELECT_TO_FLOAT_DELAY_NS);

  localparam int unsigned CNT_W = 4;

  // user request carrier
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              data;
  } req_type;

  // memory pin carrier
  typedef struct packed {
    logic              cs_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic              din;
  } pins_type;

  // gray-coded sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b011,
    ST_HOLD  = 3'b010,
    ST_READ  = 3'b110,
    ST_FLOAT = 3'b111
  } state_type;

  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

endpackage

// *** hw/sram_ctrl.sv ***
`timescale 1ns/100ps
module sram_ctrl (
  input  wire logic                           clk,        // 40 MHz clock
  input  wire logic                           reset_n,    // sync reset, active low
  input  wire logic                           req_valid,  // request offered
  input  wire sram_ctrl_pkg::req_type         req,        // write flag, address, data
  output logic                                req_ready,  // idle, request taken
  output logic                                rd_valid,   // read data pulse
  output logic                                rd_data,    // read bit
  output sram_ctrl_pkg::pins_type             mem_pins,   // memory pins
  input  wire logic                           mem_dout    // memory data output
);

  sram_ctrl_pkg::state_type                state_q;
  sram_ctrl_pkg::state_type                state_d;
  logic [sram_ctrl_pkg::CNT_W-1:0]         cnt_q;
  logic [sram_ctrl_pkg::CNT_W-1:0]         cnt_d;
  sram_ctrl_pkg::pins_type                 pins_q;
  sram_ctrl_pkg::pins_type                 pins_d;
  logic                                    ready_q;
  logic                                    ready_d;
  logic                                    rdv_q;
  logic                                    rdv_d;
  logic                                    rdd_q;
  logic                                    rdd_d;
  logic [2:0]                              dout_sync_q;
  logic                                    dout_stable_q;
  logic                                    dout_stable_d;
  logic [2:0]                              dout_sync_d;
  logic                                    take;

  // counter has reached the last cycle of its phase
  function automatic logic cnt_done(input logic [sram_ctrl_pkg::CNT_W-1:0] c);
    return (c == sram_ctrl_pkg::CNT_ZERO);
  endfunction

  // counter one step nearer zero
  function automatic logic [sram_ctrl_pkg::CNT_W-1:0] cnt_dec(
    input logic [sram_ctrl_pkg::CNT_W-1:0] c  // current count
  );
    return c - 4'h1;
  endfunction

  // load value for a phase lasting n cycles
  // every phase lasts at least one cycle
  function automatic logic [sram_ctrl_pkg::CNT_W-1:0] cnt_load(input int unsigned n);
    return 4'(n - 1);
  endfunction

  // request taken at this edge
  assign take = req_valid && ready_q;

  // sampler next values: shift the pin in, accept a level once stages two and three agree
  always_comb begin
    dout_sync_d   = {dout_sync_q[1:0], mem_dout};
    dout_stable_d = dout_stable_q;
    if (dout_sync_q[1] == dout_sync_q[2]) begin
      dout_stable_d = dout_sync_q[2];
    end
  end

  // sampler registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dout_sync_q   <= 3'h0;
      dout_stable_q <= 1'b0;
    end else begin
      dout_sync_q   <= dout_sync_d;
      dout_stable_q <= dout_stable_d;
    end
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pins_d  = pins_q;
    unique case (state_q)
      sram_ctrl_pkg::ST_IDLE: begin
        if (take) begin
          pins_d.addr  = req.addr;
          pins_d.din   = req.data;
          pins_d.cs_n  = 1'b0;
          pins_d.we_n  = 1'b1;
          if (req.write) begin
            state_d = sram_ctrl_pkg::ST_SETUP;
            cnt_d   = cnt_load(sram_ctrl_pkg::SETUP_CYCLES);
          end else begin
            state_d = sram_ctrl_pkg::ST_READ;
            cnt_d   = cnt_load(sram_ctrl_pkg::READ_WAIT_CYCLES);
          end
        end
      end
      sram_ctrl_pkg::ST_SETUP: begin
        if (cnt_done(cnt_q)) begin
          state_d     = sram_ctrl_pkg::ST_PULSE;
          pins_d.we_n = 1'b0;
          cnt_d       = cnt_load(sram_ctrl_pkg::PULSE_CYCLES);
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      sram_ctrl_pkg::ST_PULSE: begin
        if (cnt_done(cnt_q)) begin
          state_d     = sram_ctrl_pkg::ST_HOLD;
          pins_d.we_n = 1'b1;
          cnt_d       = cnt_load(sram_ctrl_pkg::HOLD_CYCLES);
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      sram_ctrl_pkg::ST_HOLD: begin
        // select held past pulse end; data held
        if (cnt_done(cnt_q)) begin
          state_d     = sram_ctrl_pkg::ST_IDLE;
          pins_d.cs_n = 1'b1;
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      sram_ctrl_pkg::ST_READ: begin
        // select access and sampler stages covered
        // result pulse comes from the read result group
        if (cnt_done(cnt_q)) begin
          state_d     = sram_ctrl_pkg::ST_FLOAT;
          pins_d.cs_n = 1'b1;
          cnt_d       = cnt_load(sram_ctrl_pkg::FLOAT_CYCLES);
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      sram_ctrl_pkg::ST_FLOAT: begin
        // let shared output float before next access
        if (cnt_done(cnt_q)) begin
          state_d = sram_ctrl_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      default: begin
        state_d     = sram_ctrl_pkg::ST_IDLE;
        pins_d.cs_n = 1'b1;
        pins_d.we_n = 1'b1;
      end
    endcase
  end

  // ready follows the sequencer into idle
  always_comb begin
    ready_d = (state_d == sram_ctrl_pkg::ST_IDLE);
  end

  // ready register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  // read result next values: pulse and capture as the read phase ends
  always_comb begin
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    if (state_q == sram_ctrl_pkg::ST_READ && cnt_done(cnt_q)) begin
      rdv_d = 1'b1;
      rdd_d = dout_stable_d;
    end
  end

  // read result registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdv_q <= 1'b0;
      rdd_q <= 1'b0;
    end else begin
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= sram_ctrl_pkg::ST_IDLE;
      cnt_q   <= sram_ctrl_pkg::CNT_ZERO;
      pins_q  <= '{cs_n: 1'b1, we_n: 1'b1, addr: '0, din: 1'b0};
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pins_q  <= pins_d;
    end
  end

  assign req_ready = ready_q;
  assign rd_valid  = rdv_q;
  assign rd_data   = rdd_q;
  assign mem_pins  = pins_q;

endmodule

// *** testbench/sram_ctrl_props.sv ***
`timescale 1ns/100ps
module sram_ctrl_props (
  input wire logic                    clk,       // clock
  input wire logic                    reset_n,   // reset
  input wire logic                    req_valid, // offered
  input wire sram_ctrl_pkg::req_type  req,       // request
  input wire logic                    req_ready, // idle
  input wire logic                    rd_valid,  // read pulse
  input wire logic                    rd_data,   // read bit
  input wire sram_ctrl_pkg::pins_type mem_pins,  // pins
  input wire logic                    mem_dout   // memory out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // short names for the pins
  wire cs_n = mem_pins.cs_n;
  wire we_n = mem_pins.we_n;
  wire take = req_valid && req_ready;
  // pin phases of one write
  sequence wr_seq;
    (!cs_n && we_n) ##1 (!cs_n && !we_n) ##1 (!cs_n && we_n) ##1 cs_n;
  endsequence
  // pin phases of one read
  sequence rd_seq;
    (!cs_n && we_n) [*4] ##1 (cs_n && rd_valid) ##1 !rd_valid;
  endsequence
  chk_write_steps: assert property (take && req.write |=> wr_seq)
    else $error("write pin order wrong");
  chk_read_steps: assert property (take && !req.write |=> rd_seq)
    else $error("read pin order wrong");
  chk_addr_given: assert property (take |=> mem_pins.addr == $past(req.addr))
    else $error("address not from request");
  chk_data_given: assert property (take |=> mem_pins.din == $past(req.data))
    else $error("data not from request");
  chk_pulse_one: assert property ($fell(we_n) |=> we_n)
    else $error("write pulse length wrong");
  chk_setup_lead: assert property ($fell(we_n) |->
    !$past(cs_n) && $stable(mem_pins.addr))
    else $error("no setup before write pulse");
  chk_addr_hold: assert property (!cs_n && !$past(cs_n) |->
    $stable(mem_pins.addr) && $stable(mem_pins.din))
    else $error("address or data moved while selected");
  chk_sel_cover: assert property (!we_n |-> !cs_n)
    else $error("write pulse without select");
  chk_idle_quiet: assert property (req_ready |-> cs_n && we_n)
    else $error("pins active while idle");
  chk_rd_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read pulse longer than one cycle");
endmodule

bind sram_ctrl sram_ctrl_props sram_ctrl_props_i (.clk(clk), .reset_n(reset_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
  .rd_data(rd_data), .mem_pins(mem_pins), .mem_dout(mem_dout));

// *** testbench/sram_model.sv ***
`timescale 1ns/100ps
module sram_model (
  input wire sram_ctrl_pkg::pins_type pins, // controller pins
  output wire logic                   dout  // data output
);
  logic mem [0:sram_ctrl_pkg::WORD_COUNT-1]; // one bit a word
  logic last = 1'b0;                         // level before float
  wire  rd = !pins.cs_n && pins.we_n;
  always @* if (!pins.cs_n && !pins.we_n) mem[pins.addr] = pins.din;
  // remember the level before floating
  always @(negedge rd) last = (dout === 1'b1);
  // drive after access, float as inverse
  assign #15 dout = rd ? mem[pins.addr] : ~last;
endmodule

// *** testbench/tb_sram_ctrl.sv ***
`timescale 1ns/100ps
module tb_sram_ctrl;
  logic                    clk = 1'b0;       // clock
  logic                    reset_n = 1'b0;   // reset
  logic                    req_valid = 1'b0; // offered
  sram_ctrl_pkg::req_type  req = '0;         // request
  logic                    req_ready;        // idle
  logic                    rd_valid;         // read pulse
  logic                    rd_data;          // read bit
  sram_ctrl_pkg::pins_type mem_pins;         // pins
  wire logic               mem_dout;         // memory out
  int                      num_errors = 0;   // mismatches
  int                      n_compared = 0;   // comparisons
  logic                    q;                // last read

  sram_ctrl sram_ctrl_i (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .mem_pins(mem_pins),
    .mem_dout(mem_dout));
  sram_model sram_model_i (.pins(mem_pins), .dout(mem_dout));

  // clock
  always #12.5 clk = ~clk;

  // compare one bit
  task automatic check(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // one request, held until taken, then back to idle
  task automatic xfer(input logic wr, input logic [9:0] a, input logic d);
    int n;
    n = 0;
    q = 1'bx;
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, data: d};
    do @(negedge clk); while (req_ready !== 1'b1 && ++n < 40);
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      if (rd_valid === 1'b1) q = rd_data;
    end while (req_ready !== 1'b1 && ++n < 40);
    @(posedge clk);
    check(n < 40, 1'b1, "no handshake");
  endtask

  // read and compare
  task automatic rd_chk(input logic [9:0] a, input logic exp);
    xfer(1'b0, a, 1'b0);
    check(q, exp, "read bit");
  endtask

  // idle pins after reset
  task automatic test_reset;
    @(negedge clk);
    check(mem_pins.cs_n, 1'b1, "select idle");
    check(mem_pins.we_n, 1'b1, "write idle");
    check(req_ready, 1'b1, "ready idle");
    @(posedge clk);
    $display("test_reset done");
  endtask

  // extreme and alternating addresses
  task automatic test_corners;
    logic [9:0] a [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    for (int i = 0; i < 4; i++) xfer(1'b1, a[i], i[0]);
    for (int i = 0; i < 4; i++) rd_chk(a[i], i[0]);
    $display("test_corners done");
  endtask

  // one address line at a time
  task automatic test_walk;
    for (int i = 0; i < 10; i++) xfer(1'b1, 10'h001 << i, ~i[0]);
    for (int i = 0; i < 10; i++) rd_chk(10'h001 << i, ~i[0]);
    $display("test_walk done");
  endtask

  // write 1 then overwrite with 0, address 3FF untouched
  task automatic test_overwrite;
    xfer(1'b1, 10'h0F0, 1'b1);
    rd_chk(10'h0F0, 1'b1);
    xfer(1'b1, 10'h0F0, 1'b0);
    rd_chk(10'h0F0, 1'b0);
    rd_chk(10'h3FF, 1'b1);
    $display("test_overwrite done");
  endtask

  // verdict and end of run
  task automatic final_report;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    test_reset();
    test_corners();
    test_walk();
    test_overwrite();
    final_report();
  end

  // watchdog
  initial begin
    #60000;
    num_errors++;
    final_report();
  end
endmodule
